// ===== rtl/fio_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
//          for the fast input/output block.
// Assumes: classic Wishbone slave, 32-bit data, byte addresses.
// Notes: bits above each documented field read as zero.
//
// Notes on behaviour
// - a rising edge on an interrupt-mode fast input raises an event.
// - every interrupt-mode input has its own event line.
// - an accepted edge opens a 10 ms lockout; edges inside it are dropped.
// - an edge while that input's handler still runs is dropped, not queued.
// - each of four fast outputs picks digital, PWM or pulse train; digital default.
// - each selected generator owns exactly its one fast output pin.
// - pulse train only on first and third outputs.
// - pulse train on first or third forces the next output to digital.
// - a digital-mode fast output drives the standard output image bit.
// - PWM or pulse-train outputs follow the generator control, not the image.
// - output modes read back; writes are ignored while running.
`ifndef FIO_REGS_SVH
`define FIO_REGS_SVH

`define FIO_NUM_IN 4
`define FIO_NUM_OUT 4

`define FIO_ADDR_W 8
`define FIO_OFF_CTRL 8'h00
`define FIO_OFF_INT_EN 8'h04
`define FIO_OFF_IN_STATUS 8'h08
`define FIO_OFF_IN_CLEAR 8'h0C
`define FIO_OFF_OUT_MODE 8'h10
`define FIO_OFF_OUT_IMAGE 8'h14
`define FIO_OFF_OUT_LEVEL 8'h18

`define FIO_CTRL_RUN_BIT 0
`define FIO_ST_BUSY_LSB 0
`define FIO_ST_LOCK_LSB 4
`define FIO_ST_DROP_LSB 8
`define FIO_ST_LEVEL_LSB 12
`define FIO_CLR_BUSY_LSB 0
`define FIO_CLR_DROP_LSB 8
`define FIO_MODE_FIELD_W 2

`define FIO_RST_CTRL 32'h0000_0000
`define FIO_RST_INT_EN 4'h0
`define FIO_RST_OUT_MODE 8'h00
`define FIO_RST_OUT_IMAGE 4'h0

`define FIO_CLK_HZ 10000000
`define FIO_LOCKOUT_MS 10
`define FIO_LOCKOUT_CYCLES (`FIO_LOCKOUT_MS * (`FIO_CLK_HZ / 1000))
`define FIO_LOCK_CNT_W 20

`endif

// ===== rtl/fio_pkg.sv
// Purpose: shared types of the fast input/output block.
// Assumes: mode codes are the default enum encoding, 0, 1 and 2.
// Notes: code 3 is never stored.
package fio_pkg;
  typedef enum logic [1:0] {
    FIO_MODE_DIGITAL,
    FIO_MODE_PWM,
    FIO_MODE_TRAIN
  } fio_mode_t;

  typedef enum logic {
    FIO_CH_READY,
    FIO_CH_LOCKOUT
  } fio_ch_state_t;
endpackage

// ===== rtl/fio_input_channel.sv
`include "fio_regs.svh"
// Purpose: one fast input: synchroniser, rising edge, lockout, handler busy.
// Assumes: pinIn is asynchronous to clk.
// Notes: only an accepted edge starts the lockout window.
module fio_input_channel #(
  parameter int LOCKOUT_CYCLES = `FIO_LOCKOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pinIn,
  input wire logic intEnable,
  input wire logic busyClear,
  input wire logic dropClear,
  output logic edgeEvent,
  output logic busy,
  output logic lockout,
  output logic dropped,
  output logic level
);
  logic syncA;
  logic prevLevel;
  logic rise;
  logic accept;
  logic [`FIO_LOCK_CNT_W-1:0] lockCount;
  fio_pkg::fio_ch_state_t state;

  // second stage is the only reader of syncA
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 1'b0;
      level <= 1'b0;
      prevLevel <= 1'b0;
    end else begin
      syncA <= pinIn;
      level <= syncA;
      prevLevel <= level;
    end
  end

  assign rise = level & ~prevLevel & intEnable;
  assign accept = rise && (state == fio_pkg::FIO_CH_READY) && !busy;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= fio_pkg::FIO_CH_READY;
      lockCount <= '0;
    end else begin
      case (state)
        fio_pkg::FIO_CH_READY: begin
          if (accept) begin
            state <= fio_pkg::FIO_CH_LOCKOUT;
            lockCount <= `FIO_LOCK_CNT_W'(LOCKOUT_CYCLES - 1);
          end
        end
        fio_pkg::FIO_CH_LOCKOUT: begin
          if (lockCount == '0) begin
            state <= fio_pkg::FIO_CH_READY;
          end else begin
            lockCount <= lockCount - 1'b1;
          end
        end
        default: begin
          state <= fio_pkg::FIO_CH_READY;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edgeEvent <= 1'b0;
      busy <= 1'b0;
      dropped <= 1'b0;
    end else begin
      edgeEvent <= accept;
      // set wins over a clear in the same cycle
      busy <= accept | (busy & ~busyClear);
      dropped <= (rise & ~accept) | (dropped & ~dropClear);
    end
  end

  assign lockout = (state == fio_pkg::FIO_CH_LOCKOUT);
endmodule

// ===== rtl/fio_top.sv
// Chosen here: register access over Wishbone and the register offsets.
`include "fio_regs.svh"
// Purpose: fast input interrupt events and fast output mode selection,
//          with a classic Wishbone register slave.
// Assumes: generator waveforms arrive on clk from logic outside this block.
// Notes: every output is registered; answers come one cycle after a request.
module fio_top #(
  parameter int LOCKOUT_CYCLES = `FIO_LOCKOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`FIO_ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // fast inputs and their events
  input wire logic [`FIO_NUM_IN-1:0] fastIn,
  output logic [`FIO_NUM_IN-1:0] fastInputEdgeEvent,
  // generator waveforms from the fast output control side, their enables, and the fast output pins
  input wire logic [`FIO_NUM_OUT-1:0] variableFrequencyPwmWave,
  input wire logic [`FIO_NUM_OUT-1:0] pulseTrainWave,
  output logic [`FIO_NUM_OUT-1:0] variableFrequencyPwmEnable,
  output logic [`FIO_NUM_OUT-1:0] pulseTrainEnable,
  output logic [`FIO_NUM_OUT-1:0] fastOut
);
  localparam int NI = `FIO_NUM_IN;
  localparam int NO = `FIO_NUM_OUT;
  localparam int MW = `FIO_MODE_FIELD_W;

  // register state
  logic runMode;
  logic [NI-1:0] intEnable;
  logic [NO*MW-1:0] outMode;
  logic [NO-1:0] outImage;

  // per-input status from the channels, and clear strobes to them
  logic [NI-1:0] chBusy;
  logic [NI-1:0] chLockout;
  logic [NI-1:0] chDropped;
  logic [NI-1:0] chLevel;
  logic [NI-1:0] busyClear;
  logic [NI-1:0] dropClear;

  // bus decode
  logic request;
  logic writeNow;
  logic [31:0] byteMask;
  logic [31:0] wrData;
  logic [31:0] next_readData;
  logic [NO*MW-1:0] next_outMode;

  // ------------------------------------------------------------------
  // wishbone: ack one cycle after the request, dropped the next cycle
  // ------------------------------------------------------------------
  assign request = cyc_i & stb_i;
  // writes take effect only at the edge where the master sees ack high
  assign writeNow = request & we_i & ack_o;

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign byteMask[8*b +: 8] = {8{sel_i[b]}};
    end
  endgenerate

  assign wrData = dat_i & byteMask;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= request & ~ack_o;
    end
  end

  // read data is sampled while the request waits for ack, and held
  always_comb begin
    next_readData = 32'h0000_0000;
    case (adr_i)
      `FIO_OFF_CTRL: begin
        next_readData[`FIO_CTRL_RUN_BIT] = runMode;
      end
      `FIO_OFF_INT_EN: begin
        next_readData[NI-1:0] = intEnable;
      end
      `FIO_OFF_IN_STATUS: begin
        next_readData[`FIO_ST_BUSY_LSB +: NI] = chBusy;
        next_readData[`FIO_ST_LOCK_LSB +: NI] = chLockout;
        next_readData[`FIO_ST_DROP_LSB +: NI] = chDropped;
        next_readData[`FIO_ST_LEVEL_LSB +: NI] = chLevel;
      end
      `FIO_OFF_OUT_MODE: begin
        next_readData[NO*MW-1:0] = outMode;
      end
      `FIO_OFF_OUT_IMAGE: begin
        next_readData[NO-1:0] = outImage;
      end
      `FIO_OFF_OUT_LEVEL: begin
        next_readData[NO-1:0] = fastOut;
      end
      default: begin
        next_readData = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_o <= 32'h0000_0000;
    end else if (request & ~ack_o & ~we_i) begin
      dat_o <= next_readData;
    end else if (!request) begin
      dat_o <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      runMode <= 1'(`FIO_RST_CTRL);
    end else if (writeNow && adr_i == `FIO_OFF_CTRL) begin
      runMode <= wrData[`FIO_CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intEnable <= `FIO_RST_INT_EN;
    end else if (writeNow && adr_i == `FIO_OFF_INT_EN) begin
      intEnable <= wrData[NI-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outImage <= `FIO_RST_OUT_IMAGE;
    end else if (writeNow && adr_i == `FIO_OFF_OUT_IMAGE) begin
      outImage <= wrData[NO-1:0];
    end
  end

  // clear strobes for the input channels are single-cycle pulses
  assign busyClear = (writeNow && adr_i == `FIO_OFF_IN_CLEAR) ?
                     wrData[`FIO_CLR_BUSY_LSB +: NI] : '0;
  assign dropClear = (writeNow && adr_i == `FIO_OFF_IN_CLEAR) ?
                     wrData[`FIO_CLR_DROP_LSB +: NI] : '0;

  // ------------------------------------------------------------------
  // output mode legalisation
  // ------------------------------------------------------------------
  // illegal codes fall back to digital rather than to a guessed generator
  always_comb begin
    next_outMode = '0;
    for (int i = 0; i < NO; i++) begin
      case (wrData[i*MW +: MW])
        MW'(fio_pkg::FIO_MODE_PWM): begin
          next_outMode[i*MW +: MW] = MW'(fio_pkg::FIO_MODE_PWM);
        end
        MW'(fio_pkg::FIO_MODE_TRAIN): begin
          if ((i % 2) == 0) begin
            next_outMode[i*MW +: MW] = MW'(fio_pkg::FIO_MODE_TRAIN);
          end else begin
            next_outMode[i*MW +: MW] = MW'(fio_pkg::FIO_MODE_DIGITAL);
          end
        end
        default: begin
          next_outMode[i*MW +: MW] = MW'(fio_pkg::FIO_MODE_DIGITAL);
        end
      endcase
    end
    for (int i = 0; i < NO; i += 2) begin
      if (next_outMode[i*MW +: MW] == MW'(fio_pkg::FIO_MODE_TRAIN)) begin
        next_outMode[(i+1)*MW +: MW] = MW'(fio_pkg::FIO_MODE_DIGITAL);
      end
    end
  end

  // mode changes only while stopped; a running generator never loses its pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outMode <= `FIO_RST_OUT_MODE;
    end else if (writeNow && adr_i == `FIO_OFF_OUT_MODE && !runMode) begin
      outMode <= next_outMode;
    end
  end

  // ------------------------------------------------------------------
  // fast output pins and generator ownership
  // ------------------------------------------------------------------
  genvar o;
  generate
    for (o = 0; o < NO; o++) begin : g_out
      fio_pkg::fio_mode_t mode;
      logic next_pin;

      assign mode = fio_pkg::fio_mode_t'(outMode[o*MW +: MW]);

      always_comb begin
        case (mode)
          fio_pkg::FIO_MODE_PWM: begin
            next_pin = variableFrequencyPwmWave[o];
          end
          fio_pkg::FIO_MODE_TRAIN: begin
            next_pin = pulseTrainWave[o];
          end
          default: begin
            next_pin = outImage[o];
          end
        endcase
      end

      // one enable per pin, so a generator drives exactly its own output
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          fastOut[o] <= 1'b0;
          variableFrequencyPwmEnable[o] <= 1'b0;
          pulseTrainEnable[o] <= 1'b0;
        end else begin
          fastOut[o] <= next_pin;
          variableFrequencyPwmEnable[o] <= (mode == fio_pkg::FIO_MODE_PWM);
          pulseTrainEnable[o] <= (mode == fio_pkg::FIO_MODE_TRAIN);
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // fast input channels
  // ------------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < NI; c++) begin : g_in
      // each channel raises its own event line
      fio_input_channel #(
        .LOCKOUT_CYCLES(LOCKOUT_CYCLES)
      ) u_channel (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(fastIn[c]),
        .intEnable(intEnable[c]),
        .busyClear(busyClear[c]),
        .dropClear(dropClear[c]),
        .edgeEvent(fastInputEdgeEvent[c]),
        .busy(chBusy[c]),
        .lockout(chLockout[c]),
        .dropped(chDropped[c]),
        .level(chLevel[c])
      );
    end
  endgenerate
endmodule

// ===== test/fio_top_asserts.sv
`include "fio_regs.svh"
// Purpose: port-level checks of the fast input/output block
// Assumes: bound to fio_top with a lockout longer than seven cycles
// Notes: outputs are judged against the waves one clock back
module fio_top_asserts #(
  parameter int LOCKOUT_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`FIO_ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [`FIO_NUM_IN-1:0] fastIn,
  input wire logic [`FIO_NUM_IN-1:0] fastInputEdgeEvent,
  input wire logic [`FIO_NUM_OUT-1:0] variableFrequencyPwmWave,
  input wire logic [`FIO_NUM_OUT-1:0] pulseTrainWave,
  input wire logic [`FIO_NUM_OUT-1:0] variableFrequencyPwmEnable,
  input wire logic [`FIO_NUM_OUT-1:0] pulseTrainEnable,
  input wire logic [`FIO_NUM_OUT-1:0] fastOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_one_mode: assert property ((variableFrequencyPwmEnable & pulseTrainEnable) == 4'h0)
    else $error("two modes on one output");
  a_train_places: assert property (!pulseTrainEnable[1] && !pulseTrainEnable[3])
    else $error("pulse train on a barred output");
  a_train_forces: assert property (
    !(pulseTrainEnable[0] && variableFrequencyPwmEnable[1])
    && !(pulseTrainEnable[2] && variableFrequencyPwmEnable[3]))
    else $error("neighbour of pulse train not digital");
  a_pwm_follows: assert property (
    ((fastOut ^ $past(variableFrequencyPwmWave)) & variableFrequencyPwmEnable) == 4'h0)
    else $error("pwm output not following wave");
  a_train_follows: assert property (
    ((fastOut ^ $past(pulseTrainWave)) & pulseTrainEnable) == 4'h0)
    else $error("train output not following wave");
  for (genvar i = 0; i < `FIO_NUM_IN; i++) begin : g_in
    a_lock_quiet: assert property (fastInputEdgeEvent[i] |=> !fastInputEdgeEvent[i] [*8])
      else $error("event inside lockout");
    a_event_pin: assert property (fastInputEdgeEvent[i] |-> $past(fastIn[i], 2))
      else $error("event without pin high");
  end
endmodule

bind fio_top fio_top_asserts #(.LOCKOUT_CYCLES(LOCKOUT_CYCLES)) u_fio_top_asserts (
  .clk(clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .fastIn(fastIn),
  .fastInputEdgeEvent(fastInputEdgeEvent), .variableFrequencyPwmWave(variableFrequencyPwmWave),
  .pulseTrainWave(pulseTrainWave), .variableFrequencyPwmEnable(variableFrequencyPwmEnable),
  .pulseTrainEnable(pulseTrainEnable), .fastOut(fastOut));

// ===== test/fio_top_tb.sv
`include "fio_regs.svh"
// Purpose: self-checking bench for the fast input/output block
// Assumes: short lockout keeps the run brief
// Notes: pin pulses last eight cycles so synchroniser jitter cannot hide them
module fio_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOCK = 20;
  logic clk, rst_n, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel, fin, ev, pwmW, trW, pwmE, trE, fout;
  logic [31:0] dw, dr, rd;
  int mismatches, check_count, evCnt[4];
  fio_top #(.LOCKOUT_CYCLES(LOCK)) u_fio_top (.clk(clk), .rst_n(rst_n), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dw), .dat_o(dr), .ack_o(ack),
    .fastIn(fin), .fastInputEdgeEvent(ev), .variableFrequencyPwmWave(pwmW),
    .pulseTrainWave(trW), .variableFrequencyPwmEnable(pwmE), .pulseTrainEnable(trE),
    .fastOut(fout));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) if (ev[i] === 1'b1) evCnt[i]++;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // holds the request until ack is sampled, then releases at that edge
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) mismatches++;
    rd = dr;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic rdchk(string n, logic [7:0] a, logic [31:0] e);
    wb(0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask
  function automatic logic [3:0] en(logic [7:0] m, logic [1:0] c);
    for (int k = 0; k < 4; k++) en[k] = (m[2*k+:2] == c);
  endfunction
  task automatic t_reset();
    chk("pins", 32'h0000_0000, {16'h0000, pwmE, trE, fout, ev});
    rdchk("mode", `FIO_OFF_OUT_MODE, 32'h0000_0000);
    rdchk("int en", `FIO_OFF_INT_EN, 32'h0000_0000);
    rdchk("unmapped", 8'h1C, 32'h0000_0000);
  endtask
  task automatic t_modes();
    logic [7:0] wr[8] = '{8'h00, 8'h55, 8'h22, 8'hAA, 8'h66, 8'h88, 8'hFF, 8'h99};
    logic [7:0] ex[8] = '{8'h00, 8'h55, 8'h22, 8'h22, 8'h22, 8'h00, 8'h00, 8'h11};
    for (int i = 0; i < 8; i++) begin
      wb(1, `FIO_OFF_OUT_MODE, {24'h0, wr[i]});
      rdchk("mode", `FIO_OFF_OUT_MODE, {24'h0, ex[i]});
      chk("pwm en", {28'h0, en(ex[i], fio_pkg::FIO_MODE_PWM)}, {28'h0, pwmE});
      chk("train en", {28'h0, en(ex[i], fio_pkg::FIO_MODE_TRAIN)}, {28'h0, trE});
    end
  endtask
  // output 0 train, output 2 pwm, outputs 1 and 3 digital
  task automatic t_outs();
    wb(1, `FIO_OFF_OUT_MODE, 32'h0000_0012);
    wb(1, `FIO_OFF_OUT_IMAGE, 32'h0000_000F);
    repeat (2) @(posedge clk);
    chk("out a", 32'h0000_000A, {28'h0, fout});
    wb(1, `FIO_OFF_OUT_IMAGE, 32'h0000_0000);
    pwmW <= 4'hF;
    trW <= 4'hF;
    repeat (2) @(posedge clk);
    chk("out b", 32'h0000_0005, {28'h0, fout});
    rdchk("level", `FIO_OFF_OUT_LEVEL, 32'h0000_0005);
    wb(1, `FIO_OFF_CTRL, 32'h0000_0001);
    wb(1, `FIO_OFF_OUT_MODE, 32'h0000_0000);
    rdchk("frozen", `FIO_OFF_OUT_MODE, 32'h0000_0012);
    wb(1, `FIO_OFF_CTRL, 32'h0000_0000);
  endtask
  task automatic pin(int b);
    @(posedge clk);
    fin[b] <= 1;
    repeat (8) @(posedge clk);
    fin[b] <= 0;
    repeat (4) @(posedge clk);
  endtask
  // input 0 stays out of interrupt mode; busy is cleared early so only the
  // lockout window can drop the second edge
  task automatic t_inputs();
    wb(1, `FIO_OFF_INT_EN, 32'h0000_000E);
    pin(0);
    pin(2);
    pin(1);
    chk("events", 32'h0000_0101, {evCnt[0][7:0], evCnt[1][7:0], evCnt[2][7:0], evCnt[3][7:0]} >> 8);
    wb(1, `FIO_OFF_IN_CLEAR, 32'h0000_0002);
    pin(1);
    chk("lockout", 32'h0000_0001, evCnt[1]);
    repeat (LOCK) @(posedge clk);
    pin(1);
    chk("after lockout", 32'h0000_0002, evCnt[1]);
    repeat (LOCK) @(posedge clk);
    pin(1);
    chk("busy", 32'h0000_0002, evCnt[1]);
    rdchk("status", `FIO_OFF_IN_STATUS, 32'h0000_0206);
    wb(1, `FIO_OFF_IN_CLEAR, 32'h0000_0202);
    pin(1);
    chk("again", 32'h0000_0003, evCnt[1]);
    rdchk("status b", `FIO_OFF_IN_STATUS, 32'h0000_0026);
  endtask
  initial begin
    rst_n = 0;
    {cyc, stb, we, adr, sel, dw, fin, pwmW, trW} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_modes();
    t_outs();
    t_inputs();
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
endmodule
